// ==== common/dac_pkg.sv ====
package dac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_SELECT = 8'hE8;
    localparam logic [7:0] IDX_BUF = 8'hE9;
    localparam logic [7:0] IDX_DST_REMAINING_COUNT = 8'hEA;
    localparam logic [7:0] IDX_DST_LIVE_POINTER = 8'hEC;
    localparam logic [7:0] IDX_DSZ = 8'hEE;
    localparam logic [7:0] IDX_DSA = 8'hF0;
    localparam logic [7:0] IDX_SRC_REMAINING_COUNT = 8'hF2;
    localparam logic [7:0] IDX_SRC_LIVE_POINTER = 8'hF4;
    localparam logic [7:0] IDX_SSZ = 8'hF7;
    localparam logic [7:0] IDX_SSA = 8'hF9;
    localparam logic [7:0] IDX_CTRL0 = 8'hFC;
    localparam logic [7:0] IDX_CTRL1 = 8'hFD;
    localparam logic [7:0] IDX_ABORT = 8'hFE;
    localparam logic [7:0] IDX_START = 8'hFF;
    // Byte lane offsets of the high and upper lanes from the low lane.
    localparam logic [7:0] LANE_H = 8'h01;
    localparam logic [7:0] LANE_U = 8'h02;

    ////////////////////////////////////////////////////////////////////////
    // Control field positions.
    localparam int CTRL0_EN_BIT = 7;
    localparam int CTRL0_SEN_BIT = 6;
    localparam int CTRL0_AEN_BIT = 2;
    localparam int CTRL0_XIP_BIT = 0;
    localparam int CTRL1_SSTP_BIT = 0;
    localparam int CTRL1_SRC_STEP_MODE_LSB = 1;
    localparam int CTRL1_SMR_LSB = 3;
    localparam int CTRL1_DSTP_BIT = 5;
    localparam int CTRL1_DST_STEP_MODE_LSB = 6;
    localparam logic [1:0] MODE_HOLD = 2'h0;
    localparam logic [1:0] MODE_INC = 2'h1;
    localparam logic [1:0] MODE_DEC = 2'h2;
    localparam logic [1:0] REGION_DATA = 2'h0;
    localparam logic [1:0] REGION_FLASH = 2'h1;
    localparam logic [1:0] REGION_EEPROM = 2'h2;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Trigger code table.
    localparam int NCH_MAX = 4;
    localparam logic [7:0] EVT_BASE [NCH_MAX] = '{8'h14, 8'h34, 8'h4C, 8'h54};
    localparam int EV_SRC = 0;
    localparam int EV_DST = 1;
    localparam int EV_OVR = 2;
    localparam int EV_ABT = 3;
    localparam int EV_PER_CH = 4;
    localparam logic [7:0] TRIG_NONE = 8'h00;
    localparam logic [7:0] TRIG_ADC_DONE = 8'h0A;
    localparam logic [7:0] TRIG_SPI1_RX = 8'h18;
    localparam logic [7:0] TRIG_SPI1_TX = 8'h19;
    localparam logic [7:0] TRIG_UART1_RX = 8'h20;
    localparam logic [7:0] TRIG_UART1_TX = 8'h21;
    localparam logic [255:0] NO_SRC_MASK = (256'h1 << 8'h00) |
        (256'h1 << 8'h0E) | (256'h1 << 8'h11) | (256'h1 << 8'h12) |
        (256'h1 << 8'h13) | (256'h1 << 8'h2B) | (256'h1 << 8'h31) |
        (256'h1 << 8'h3C) | (256'h1 << 8'h44) | (256'h1 << 8'h46) |
        (256'h1 << 8'h51) | (256'h1 << 8'h52);

    ////////////////////////////////////////////////////////////////////////
    // Memory side carriers.
    typedef struct packed {
        logic req;
        logic [1:0] region;
        logic [21:0] addr;
    } dac_rd_req_t;

    typedef struct packed {
        logic req;
        logic [15:0] addr;
        logic [7:0] data;
    } dac_wr_req_t;

endpackage

// ==== verilog/dac_top.sv ====
`timescale 1ns/10ps
// Function
// - Read-only buffer byte shows the byte being moved.
// - Writable 22-bit source start address over three lanes, resets zero.
// - Writable 12-bit source message size.
// - Readable 12-bit remaining source byte count.
// - Read-only 22-bit live source pointer, resets zero.
// - Writable 16-bit destination start address over two lanes.
// - Writable 12-bit destination message size.
// - Readable 12-bit remaining destination byte count.
// - Read-only 16-bit live destination pointer, resets zero.
// - Values split into upper, high and low byte registers.
// - 8-bit start trigger code; zero and dash codes select nothing.
// - Abort trigger code uses the same code table.
// - Channel events selectable as triggers in groups of four.
// - Peripheral trigger codes follow the fixed code table.
// - Source pointer holds, increments or decrements by 2-bit mode.
// - Destination pointer holds, increments or decrements by 2-bit mode.
// - Source region: data space, program flash or data EEPROM.
// - Shared register window; select value n below NCH reaches channel n.
module dac_top #(
    parameter int NCH = 4
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [255:0] TRIG_I,
    output dac_pkg::dac_rd_req_t MEM_RD_O,
    input wire logic MEM_RD_ACK_I,
    input wire logic [7:0] MEM_RD_DATA_I,
    output dac_pkg::dac_wr_req_t MEM_WR_O,
    input wire logic MEM_WR_ACK_I,
    output logic [4*NCH-1:0] EVT_O
);
    import dac_pkg::*;

    localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

    if (NCH < 1 || NCH > NCH_MAX) begin : g_bad_nch
        $error("NCH must lie between 1 and 4.");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dac_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Channel state.
    logic [21:0] ssa_reg [NCH];
    logic [11:0] ssz_reg [NCH];
    logic [11:0] src_remaining_count_reg [NCH];
    logic [21:0] src_live_pointer_reg [NCH];
    logic [15:0] dsa_reg [NCH];
    logic [11:0] dsz_reg [NCH];
    logic [11:0] dst_remaining_count_reg [NCH];
    logic [15:0] dst_live_pointer_reg [NCH];
    logic [7:0] ctrl1_reg [NCH];
    logic [7:0] start_trigger_code_reg [NCH];
    logic [7:0] abort_trigger_code_reg [NCH];
    logic [7:0] buf_reg [NCH];
    logic [NCH-1:0] en_reg, sen_reg, aen_reg, xip_reg, pend_reg;
    logic [2:0] sel_reg;
    logic wr_vld_reg;
    logic [7:0] wr_idx_reg;
    dac_state_t state_reg;
    logic [CW-1:0] act_reg;
    logic [4*NCH-1:0] evt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    wire ahb_go = HSEL_I & HREADY_I & HTRANS_I[1];
    wire addr_ok = (HADDR_I[31:10] == 22'h0) & (HADDR_I[1:0] == 2'h0);
    wire [7:0] acc_idx = HADDR_I[9:2];
    wire sel_ok = ({29'h0, sel_reg} < 32'(NCH));
    wire [CW-1:0] cs = sel_reg[CW-1:0];
    wire [7:0] wd = HWDATA_I[7:0];
    wire we_ch = wr_vld_reg & sel_ok;

    function automatic logic [7:0] rd_mux(input logic [7:0] idx);
        logic [7:0] v;
        v = BYTE_RESET;
        if (idx == IDX_SELECT) begin
            v = {5'h0, sel_reg};
        end else if (sel_ok) begin
            case (idx)
                IDX_BUF: v = buf_reg[cs];
                IDX_DST_REMAINING_COUNT: v = dst_remaining_count_reg[cs][7:0];
                IDX_DST_REMAINING_COUNT + LANE_H: v = {4'h0, dst_remaining_count_reg[cs][11:8]};
                IDX_DST_LIVE_POINTER: v = dst_live_pointer_reg[cs][7:0];
                IDX_DST_LIVE_POINTER + LANE_H: v = dst_live_pointer_reg[cs][15:8];
                IDX_DSZ: v = dsz_reg[cs][7:0];
                IDX_DSZ + LANE_H: v = {4'h0, dsz_reg[cs][11:8]};
                IDX_DSA: v = dsa_reg[cs][7:0];
                IDX_DSA + LANE_H: v = dsa_reg[cs][15:8];
                IDX_SRC_REMAINING_COUNT: v = src_remaining_count_reg[cs][7:0];
                IDX_SRC_REMAINING_COUNT + LANE_H: v = {4'h0, src_remaining_count_reg[cs][11:8]};
                IDX_SRC_LIVE_POINTER: v = src_live_pointer_reg[cs][7:0];
                IDX_SRC_LIVE_POINTER + LANE_H: v = src_live_pointer_reg[cs][15:8];
                IDX_SRC_LIVE_POINTER + LANE_U: v = {2'h0, src_live_pointer_reg[cs][21:16]};
                IDX_SSZ: v = ssz_reg[cs][7:0];
                IDX_SSZ + LANE_H: v = {4'h0, ssz_reg[cs][11:8]};
                IDX_SSA: v = ssa_reg[cs][7:0];
                IDX_SSA + LANE_H: v = ssa_reg[cs][15:8];
                IDX_SSA + LANE_U: v = {2'h0, ssa_reg[cs][21:16]};
                IDX_CTRL0: v = {en_reg[cs], sen_reg[cs], 3'h0,
                    aen_reg[cs], 1'b0, xip_reg[cs]};
                IDX_CTRL1: v = ctrl1_reg[cs];
                IDX_ABORT: v = abort_trigger_code_reg[cs];
                IDX_START: v = start_trigger_code_reg[cs];
                default: v = BYTE_RESET;
            endcase
        end
        return v;
    endfunction

    function automatic logic [21:0] step_ptr(input logic [21:0] p,
        input logic [1:0] m);
        logic [21:0] r;
        case (m)
            MODE_INC: r = p + 22'h1;
            MODE_DEC: r = p - 22'h1;
            default: r = p;
        endcase
        return r;
    endfunction

    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = addr_ok ? rd_mux(acc_idx) : BYTE_RESET;
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger decode and transfer events.
    logic [255:0] trig_all;
    logic [NCH-1:0] start_hit, abort_hit, src_adv, dst_adv;
    logic [NCH-1:0] src_wrap, dst_wrap, sw_wr, en_rise, ovr_hit;
    logic [21:0] src_live_pointer_nx [NCH];
    logic [21:0] dst_live_pointer_nx [NCH];
    logic grant_vld;
    logic [CW-1:0] grant_ch;

    always_comb begin
        trig_all = TRIG_I & ~NO_SRC_MASK;
        for (int c = 0; c < NCH; c++) begin
            for (int k = 0; k < EV_PER_CH; k++) begin
                trig_all[EVT_BASE[c] + k] = evt_reg[c*EV_PER_CH + k];
            end
        end
    end

    always_comb begin
        grant_vld = 1'b0;
        grant_ch = '0;
        for (int c = NCH - 1; c >= 0; c--) begin
            start_hit[c] = en_reg[c] & sen_reg[c] & trig_all[start_trigger_code_reg[c]];
            abort_hit[c] = en_reg[c] & aen_reg[c] & trig_all[abort_trigger_code_reg[c]];
            ovr_hit[c] = start_hit[c] & pend_reg[c];
            src_adv[c] = (state_reg == ST_READ) & (act_reg == CW'(c)) &
                MEM_RD_ACK_I & ~abort_hit[c] & en_reg[c];
            dst_adv[c] = (state_reg == ST_WRITE) & (act_reg == CW'(c)) &
                MEM_WR_ACK_I & ~abort_hit[c] & en_reg[c];
            src_wrap[c] = src_adv[c] & (src_remaining_count_reg[c] <= 12'h1);
            dst_wrap[c] = dst_adv[c] & (dst_remaining_count_reg[c] <= 12'h1);
            sw_wr[c] = we_ch & (cs == CW'(c));
            en_rise[c] = sw_wr[c] & (wr_idx_reg == IDX_CTRL0) &
                wd[CTRL0_EN_BIT] & ~en_reg[c];
            src_live_pointer_nx[c] = step_ptr(src_live_pointer_reg[c],
                ctrl1_reg[c][CTRL1_SRC_STEP_MODE_LSB +: 2]);
            dst_live_pointer_nx[c] = step_ptr({6'h0, dst_live_pointer_reg[c]},
                ctrl1_reg[c][CTRL1_DST_STEP_MODE_LSB +: 2]);
            if (pend_reg[c] & en_reg[c] & ~abort_hit[c]) begin
                grant_vld = 1'b1;
                grant_ch = CW'(c);
            end
        end
    end

    wire kill = abort_hit[act_reg] | ~en_reg[act_reg];
    wire [1:0] src_region_select = ctrl1_reg[grant_ch][CTRL1_SMR_LSB +: 2];
    wire [1:0] region = src_region_select[1] ? REGION_EEPROM : src_region_select;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave.
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            HRDATA_O <= 32'h0;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
            wr_vld_reg <= 1'b0;
            wr_idx_reg <= BYTE_RESET;
            sel_reg <= SELECT_RESET;
        end else begin
            HRDATA_O <= (ahb_go & ~HWRITE_I) ? {24'h0, rd_byte} : 32'h0;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
            wr_vld_reg <= ahb_go & HWRITE_I & addr_ok;
            wr_idx_reg <= acc_idx;
            if (wr_vld_reg && wr_idx_reg == IDX_SELECT) begin
                sel_reg <= wd[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine.
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg <= ST_IDLE;
            act_reg <= '0;
            MEM_RD_O <= '0;
            MEM_WR_O <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (grant_vld) begin
                        state_reg <= ST_READ;
                        act_reg <= grant_ch;
                        MEM_RD_O <= {1'b1, region, src_live_pointer_reg[grant_ch]};
                    end
                end
                ST_READ: begin
                    if (kill) begin
                        state_reg <= ST_IDLE;
                        MEM_RD_O.req <= 1'b0;
                    end else if (MEM_RD_ACK_I) begin
                        state_reg <= ST_WRITE;
                        MEM_RD_O.req <= 1'b0;
                        MEM_WR_O <= {1'b1, dst_live_pointer_reg[act_reg], MEM_RD_DATA_I};
                    end
                end
                ST_WRITE: begin
                    if (kill || MEM_WR_ACK_I) begin
                        state_reg <= ST_IDLE;
                        MEM_WR_O.req <= 1'b0;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel registers: engine updates first, software writes after.
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int c = 0; c < NCH; c++) begin
                ssa_reg[c] <= 22'h0;
                ssz_reg[c] <= 12'h0;
                src_remaining_count_reg[c] <= 12'h0;
                src_live_pointer_reg[c] <= 22'h0;
                dsa_reg[c] <= 16'h0;
                dsz_reg[c] <= 12'h0;
                dst_remaining_count_reg[c] <= 12'h0;
                dst_live_pointer_reg[c] <= 16'h0;
                ctrl1_reg[c] <= BYTE_RESET;
                start_trigger_code_reg[c] <= TRIG_NONE;
                abort_trigger_code_reg[c] <= TRIG_NONE;
                buf_reg[c] <= BYTE_RESET;
            end
            en_reg <= '0;
            sen_reg <= '0;
            aen_reg <= '0;
            xip_reg <= '0;
            pend_reg <= '0;
            evt_reg <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                evt_reg[c*EV_PER_CH + EV_SRC] <= src_wrap[c];
                evt_reg[c*EV_PER_CH + EV_DST] <= dst_wrap[c];
                evt_reg[c*EV_PER_CH + EV_OVR] <= ovr_hit[c];
                evt_reg[c*EV_PER_CH + EV_ABT] <= abort_hit[c];
                if (start_hit[c]) begin
                    pend_reg[c] <= 1'b1;
                end else if (abort_hit[c] || (state_reg == ST_IDLE &&
                    grant_vld && grant_ch == CW'(c))) begin
                    pend_reg[c] <= 1'b0;
                end
                if (src_adv[c]) begin
                    buf_reg[c] <= MEM_RD_DATA_I;
                    xip_reg[c] <= 1'b1;
                    if (src_wrap[c]) begin
                        src_remaining_count_reg[c] <= ssz_reg[c];
                        src_live_pointer_reg[c] <= ssa_reg[c];
                    end else begin
                        src_remaining_count_reg[c] <= src_remaining_count_reg[c] - 12'h1;
                        src_live_pointer_reg[c] <= src_live_pointer_nx[c];
                    end
                end
                if (dst_adv[c]) begin
                    xip_reg[c] <= 1'b0;
                    if (dst_wrap[c]) begin
                        dst_remaining_count_reg[c] <= dsz_reg[c];
                        dst_live_pointer_reg[c] <= dsa_reg[c];
                    end else begin
                        dst_remaining_count_reg[c] <= dst_remaining_count_reg[c] - 12'h1;
                        dst_live_pointer_reg[c] <= dst_live_pointer_nx[c][15:0];
                    end
                end
                if (abort_hit[c]) begin
                    xip_reg[c] <= 1'b0;
                end
                if ((src_wrap[c] & ctrl1_reg[c][CTRL1_SSTP_BIT]) |
                    (dst_wrap[c] & ctrl1_reg[c][CTRL1_DSTP_BIT])) begin
                    sen_reg[c] <= 1'b0;
                end
                if (en_rise[c]) begin
                    src_remaining_count_reg[c] <= ssz_reg[c];
                    src_live_pointer_reg[c] <= ssa_reg[c];
                    dst_remaining_count_reg[c] <= dsz_reg[c];
                    dst_live_pointer_reg[c] <= dsa_reg[c];
                end
                if (sw_wr[c]) begin
                    case (wr_idx_reg)
                        IDX_SSA: ssa_reg[c][7:0] <= wd;
                        IDX_SSA + LANE_H: ssa_reg[c][15:8] <= wd;
                        IDX_SSA + LANE_U: ssa_reg[c][21:16] <= wd[5:0];
                        IDX_SSZ: ssz_reg[c][7:0] <= wd;
                        IDX_SSZ + LANE_H: ssz_reg[c][11:8] <= wd[3:0];
                        IDX_DSA: dsa_reg[c][7:0] <= wd;
                        IDX_DSA + LANE_H: dsa_reg[c][15:8] <= wd;
                        IDX_DSZ: dsz_reg[c][7:0] <= wd;
                        IDX_DSZ + LANE_H: dsz_reg[c][11:8] <= wd[3:0];
                        IDX_CTRL0: begin
                            en_reg[c] <= wd[CTRL0_EN_BIT];
                            sen_reg[c] <= wd[CTRL0_SEN_BIT];
                            aen_reg[c] <= wd[CTRL0_AEN_BIT];
                        end
                        IDX_CTRL1: ctrl1_reg[c] <= wd;
                        IDX_ABORT: abort_trigger_code_reg[c] <= wd;
                        IDX_START: start_trigger_code_reg[c] <= wd;
                        default: ;
                    endcase
                end
            end
        end
    end

    always_comb begin
        EVT_O = evt_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);

    AST_BUF_CAPTURE: assert property (
        src_adv[act_reg] |=> buf_reg[act_reg] == $past(MEM_RD_DATA_I))
        else $error("Buffer did not capture the read byte.");
    AST_SSA_UPPER_LANE: assert property (
        ahb_go & ~HWRITE_I & addr_ok & sel_ok &
        (acc_idx == IDX_SSA + LANE_U) |=>
        HRDATA_O == {26'h0, $past(ssa_reg[cs][21:16])})
        else $error("Upper source start lane read wrong.");
    AST_SEL_ROUTE: assert property (
        we_ch & (wr_idx_reg == IDX_DSA) |=>
        dsa_reg[$past(cs)][7:0] == $past(wd))
        else $error("Write not routed to selected channel.");
    AST_SRC_LIVE_POINTER_RO: assert property (
        sw_wr[0] & (wr_idx_reg == IDX_SRC_LIVE_POINTER) & ~src_adv[0] & ~en_rise[0]
        |=> $stable(src_live_pointer_reg[0]))
        else $error("Software changed the source pointer.");
    AST_SRC_INC: assert property (
        src_adv[0] & ~src_wrap[0] & ~en_rise[0] &
        (ctrl1_reg[0][CTRL1_SRC_STEP_MODE_LSB +: 2] == MODE_INC)
        |=> src_live_pointer_reg[0] == $past(src_live_pointer_reg[0]) + 22'h1)
        else $error("Source pointer did not increment.");
    AST_DST_DEC: assert property (
        dst_adv[0] & ~dst_wrap[0] & ~en_rise[0] &
        (ctrl1_reg[0][CTRL1_DST_STEP_MODE_LSB +: 2] == MODE_DEC)
        |=> dst_live_pointer_reg[0] == $past(dst_live_pointer_reg[0]) - 16'h1)
        else $error("Destination pointer did not decrement.");
    AST_SRC_RELOAD: assert property (
        src_wrap[0] & ~en_rise[0] |=>
        (src_remaining_count_reg[0] == $past(ssz_reg[0])) & evt_reg[EV_SRC] ##1
        ~evt_reg[EV_SRC] | src_wrap[0])
        else $error("Source count reload or done event wrong.");
    AST_DST_RELOAD: assert property (
        dst_wrap[0] & ~en_rise[0] |=>
        (dst_live_pointer_reg[0] == $past(dsa_reg[0])) & evt_reg[EV_DST])
        else $error("Destination reload or done event wrong.");
    AST_REGION: assert property (
        $rose(MEM_RD_O.req) |->
        MEM_RD_O.region == (ctrl1_reg[act_reg][CTRL1_SMR_LSB + 1] ?
        REGION_EEPROM : ctrl1_reg[act_reg][CTRL1_SMR_LSB +: 2]))
        else $error("Source region wrong on read request.");
    AST_CODE_NONE: assert property (
        start_hit[0] |-> (start_trigger_code_reg[0] != TRIG_NONE))
        else $error("Code zero started a transfer.");
    AST_ABORT_EVENT: assert property (
        abort_hit[0] |=> evt_reg[EV_ABT] &
        ((state_reg == ST_IDLE) | (act_reg != '0)))
        else $error("Abort did not end the transfer.");

    CVR_SRC_WRAP: cover property (src_wrap[0]);
    CVR_DST_WRAP: cover property (dst_wrap[0] ##1 evt_reg[EV_DST]);
    CVR_ABORT_KILL: cover property ((state_reg == ST_READ) & kill);
    CVR_OVERRUN: cover property (ovr_hit[0]);

endmodule // dac_top

// ==== tb/dac_mem_model.sv ====
`timescale 1ns/10ps
// Slow memory: acks one request after LAT+1 waiting cycles, returns addr ^ 5A.
module dac_mem_model #(
    parameter int LAT = 3
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire dac_pkg::dac_rd_req_t rd_i,
    input wire dac_pkg::dac_wr_req_t wr_i,
    output logic rd_ack_o,
    output logic [7:0] rd_data_o,
    output logic wr_ack_o
);
    import dac_pkg::*;
    int cnt;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 0;
            rd_ack_o <= 1'b0;
            wr_ack_o <= 1'b0;
            rd_data_o <= 8'hA5;
        end else begin
            rd_ack_o <= 1'b0;
            wr_ack_o <= 1'b0;
            rd_data_o <= ~rd_data_o;
            if ((rd_i.req || wr_i.req) && !rd_ack_o && !wr_ack_o) begin
                cnt <= (cnt == LAT) ? 0 : cnt + 1;
                if (cnt == LAT) begin
                    rd_ack_o <= rd_i.req;
                    wr_ack_o <= wr_i.req && !rd_i.req;
                    rd_data_o <= rd_i.addr[7:0] ^ 8'h5A;
                end
            end else if (!rd_i.req && !wr_i.req) begin
                cnt <= 0;
            end
        end
    end
endmodule // dac_mem_model

// ==== tb/dac_top_tb.sv ====
`timescale 1ns/10ps
module dac_top_tb;
    import dac_pkg::*;
    logic clk = 0, rst_b = 0, hwr = 0, hrdy, hresp, rack, wack;
    logic [1:0] htr = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd;
    logic [7:0] rdat;
    logic [255:0] trig = '0;
    logic [15:0] evt;
    dac_rd_req_t rreq;
    dac_wr_req_t wreq;
    int err_total = 0, cmp_count = 0, dones = 0, acks = 0, n0;
    int dsts = 0, aborts = 0;
    logic [23:0] wlast = '0;
    logic hbad = 1'b0;
    dac_top dac_top_inst (.CLK_SYS_I(clk), .RST_B_I(rst_b), .HSEL_I(1'b1),
        .HADDR_I(ha), .HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2),
        .HWDATA_I(hwd), .HREADY_I(hrdy), .HRDATA_O(hrd),
        .HREADYOUT_O(hrdy), .HRESP_O(hresp), .TRIG_I(trig),
        .MEM_RD_O(rreq), .MEM_RD_ACK_I(rack), .MEM_RD_DATA_I(rdat),
        .MEM_WR_O(wreq), .MEM_WR_ACK_I(wack), .EVT_O(evt));
    dac_mem_model dac_mem_model_inst (.clk_i(clk), .rst_b_i(rst_b),
        .rd_i(rreq), .wr_i(wreq), .rd_ack_o(rack), .rd_data_o(rdat),
        .wr_ack_o(wack));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        dones <= dones + (evt[0] === 1'b1);
        dsts <= dsts + (evt[1] === 1'b1);
        aborts <= aborts + (evt[3] === 1'b1);
        acks <= acks + (rack === 1'b1);
        if (wack === 1'b1)
            wlast <= {wreq.addr, wreq.data};
        if (rst_b === 1'b1 && hresp !== 1'b0)
            hbad <= 1'b1;
    end
    task automatic complete_run;
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic hold;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            complete_run;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ix,
        input logic [7:0] d, output logic [7:0] r);
        htr <= 2'h2;
        hwr <= w;
        ha <= {22'h0, ix, 2'h0};
        hold;
        htr <= 2'h0;
        hwd <= {24'h0, d};
        hold;
        r = hrd[7:0];
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, ix, d, r);
    endtask
    task automatic rd(input logic [7:0] ix, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, ix, 8'h00, r);
        chk(r, e);
    endtask
    task automatic fire(input logic [7:0] c);
        int n;
        n = 0;
        trig[c] <= 1'b1;
        @(posedge clk);
        trig[c] <= 1'b0;
        while (wack !== 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
        if (n >= 80) begin
            err_total++;
            complete_run;
        end
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(IDX_SSA + LANE_U, 8'h00);
        rd(IDX_SRC_LIVE_POINTER, 8'h00);
        rd(IDX_DST_LIVE_POINTER + LANE_H, 8'h00);
        rd(IDX_BUF, 8'h00);
        rd(8'h10, 8'h00);
        $display("reset test done");
        wr(IDX_SSA + LANE_U, 8'hFF);
        rd(IDX_SSA + LANE_U, 8'h3F);
        wr(IDX_SSA + LANE_U, 8'h00);
        wr(IDX_SSA + LANE_H, 8'h00);
        wr(IDX_SSA, 8'h10);
        wr(IDX_SSZ + LANE_H, 8'hFF);
        rd(IDX_SSZ + LANE_H, 8'h0F);
        wr(IDX_SSZ + LANE_H, 8'h00);
        wr(IDX_SSZ, 8'h02);
        wr(IDX_DSZ + LANE_H, 8'hFF);
        rd(IDX_DSZ + LANE_H, 8'h0F);
        wr(IDX_DSZ + LANE_H, 8'h00);
        wr(IDX_DSZ, 8'h02);
        wr(IDX_DSA + LANE_H, 8'h02);
        wr(IDX_DSA, 8'h00);
        rd(IDX_DSA + LANE_H, 8'h02);
        wr(IDX_SRC_LIVE_POINTER, 8'h55);
        rd(IDX_SRC_LIVE_POINTER, 8'h00);
        wr(IDX_START, TRIG_UART1_TX);
        wr(IDX_CTRL1, 8'h82);
        wr(IDX_CTRL0, 8'hC0);
        rd(IDX_SRC_REMAINING_COUNT, 8'h02);
        rd(IDX_DST_REMAINING_COUNT, 8'h02);
        $display("register test done");
        fire(TRIG_UART1_TX);
        rd(IDX_BUF, 8'h4A);
        rd(IDX_SRC_REMAINING_COUNT, 8'h01);
        rd(IDX_SRC_LIVE_POINTER, 8'h11);
        rd(IDX_DST_REMAINING_COUNT, 8'h01);
        rd(IDX_DST_LIVE_POINTER, 8'hFF);
        rd(IDX_DST_LIVE_POINTER + LANE_H, 8'h01);
        chk(wlast[7:0], 8'h4A);
        chk(wlast[23:16], 8'h02);
        fire(TRIG_UART1_TX);
        rd(IDX_BUF, 8'h4B);
        rd(IDX_SRC_REMAINING_COUNT, 8'h02);
        rd(IDX_SRC_LIVE_POINTER, 8'h10);
        rd(IDX_DST_LIVE_POINTER + LANE_H, 8'h02);
        chk(8'(dones), 8'h01);
        chk(8'(dsts), 8'h01);
        chk(wlast[15:8], 8'hFF);
        $display("transfer test done");
        wr(IDX_SELECT, 8'h01);
        rd(IDX_SSA, 8'h00);
        wr(IDX_SELECT, 8'h00);
        rd(IDX_SSA, 8'h10);
        wr(IDX_ABORT, TRIG_ADC_DONE);
        rd(IDX_ABORT, 8'h0A);
        wr(IDX_CTRL0, 8'hC4);
        n0 = acks;
        trig[TRIG_UART1_TX] <= 1'b1;
        @(posedge clk);
        trig[TRIG_UART1_TX] <= 1'b0;
        repeat (2) @(posedge clk);
        trig[TRIG_ADC_DONE] <= 1'b1;
        @(posedge clk);
        trig[TRIG_ADC_DONE] <= 1'b0;
        repeat (20) @(posedge clk);
        chk(8'(acks), 8'(n0));
        chk(8'(aborts), 8'h01);
        rd(IDX_SRC_LIVE_POINTER, 8'h10);
        wr(IDX_START, TRIG_NONE);
        n0 = acks;
        trig[0] <= 1'b1;
        @(posedge clk);
        trig[0] <= 1'b0;
        repeat (20) @(posedge clk);
        chk(8'(acks), 8'(n0));
        chk(8'(hbad), 8'h00);
        $display("select and code test done");
        complete_run;
    end
endmodule // dac_top_tb
